// ### verilog/pse_pkg.sv
/*
 Constants, types and register map of the four-level symbol error checker.
 Assumes one 40 MHz clock and an AHB-Lite register port.
*/
// Overview of operation
// R1 - Sample all three comparators on one edge.
// R2 - Thermometer code maps to level by table.
// R3 - Each level also gets its Gray code.
// R4 - Compare decoded symbol with expected, count mismatches.
// R5 - Per-value compared and errored symbol counts.
// R6 - Counters update live with every symbol.
// R7 - Table decode counts one error per symbol.
// R8 - Long pseudo-random generator serves as expected source.
// R9 - Pattern memory holds a mask per symbol.
// R10 - Three-slicer mode masks slicers by expected value.
// R11 - Expected zero: only lower slicer counts.
// R12 - Three-slicer mode needs aligned slicer channels.
// R13 - Three-slicer mode only with memory patterns.
// R14 - Each slicer threshold set independently.
// R15 - Total bit errors combine both bit streams.
// R16 - Expected source selectable: generator or memory.
// R17 - Bit errors by Gray difference; bits plus two.
// R18 - Start clears all counters; counters saturate.
package pse_pkg;
    localparam int         ADDR_W    = 8;
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_STAT  = 8'h04;
    localparam logic [7:0] OFS_MASK  = 8'h08;
    localparam logic [7:0] OFS_THR_U = 8'h0C;
    localparam logic [7:0] OFS_THR_M = 8'h10;
    localparam logic [7:0] OFS_THR_L = 8'h14;
    localparam logic [7:0] OFS_SEED  = 8'h18;
    localparam logic [7:0] OFS_PLEN  = 8'h1C;
    localparam logic [7:0] OFS_PADR  = 8'h20;
    localparam logic [7:0] OFS_PDAT  = 8'h24;
    localparam logic [7:0] OFS_SYMS  = 8'h28;
    localparam logic [7:0] OFS_SYME  = 8'h2C;
    localparam logic [7:0] OFS_BITS  = 8'h30;
    localparam logic [7:0] OFS_BITE  = 8'h34;
    localparam logic [7:0] OFS_BEMS  = 8'h38;
    localparam logic [7:0] OFS_BELS  = 8'h3C;
    localparam logic [3:0] PAGE_SCMP = 4'h4;
    localparam logic [3:0] PAGE_SERR = 4'h5;
    localparam logic [7:0] OFS_RXST  = 8'h60;
    // Control bits.
    localparam int CTL_EN    = 0;
    localparam int CTL_MEM   = 1;
    localparam int CTL_SLC   = 2;
    localparam int CTL_START = 3;
    localparam int CTL_W     = 3;
    // Interrupt status bits.
    localparam int IRQ_SERR = 0;
    localparam int IRQ_SAT  = 1;
    localparam int IRQ_WRAP = 2;
    localparam int IRQ_W    = 3;
    localparam logic [7:0]  THR_U_RST = 8'hC0;
    localparam logic [7:0]  THR_M_RST = 8'h80;
    localparam logic [7:0]  THR_L_RST = 8'h40;
    localparam logic [30:0] SEED_RST  = 31'h7FFFFFFF;
    localparam int          PRBS_TA   = 30;
    localparam int          PRBS_TB   = 27;
    // Relevant slicers per expected level, order upper/middle/lower.
    localparam logic [2:0] REL_L0 = 3'h1;
    localparam logic [2:0] REL_L1 = 3'h3;
    localparam logic [2:0] REL_L2 = 3'h6;
    localparam logic [2:0] REL_L3 = 3'h4;

    typedef enum logic [2:0] {
        BS_IDLE = 3'b001,
        BS_WAIT = 3'b010,
        BS_DONE = 3'b100
    } pse_bus_t;

    typedef struct packed {
        logic upp;
        logic mid;
        logic low;
    } pse_samp_t;

    typedef struct packed {
        logic [2:0] mask;
        logic [1:0] lvl;
    } pse_pat_t;
endpackage

// ### verilog/pse_checker.sv
/*
 Four-level symbol error checker with AHB-Lite register slave.
 Assumes comparator bits and sym_valid are synchronous to clk, and a
 single AHB master whose hready is this slave's hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none
module pse_checker #(
    parameter int CNT_W = 32,
    parameter int PAT_D = 256,
    parameter int THR_W = 8
) (
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              rst_b,
    // AHB-Lite slave.
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    // Comparator inputs.
    input  wire logic              cmp_upp,
    input  wire logic              cmp_mid,
    input  wire logic              cmp_low,
    input  wire logic              sym_valid,
    input  wire logic              slc_aligned,
    // Threshold settings and decoded symbol.
    output logic [THR_W-1:0]       thr_upp,
    output logic [THR_W-1:0]       thr_mid,
    output logic [THR_W-1:0]       thr_low,
    output logic [1:0]             rx_level,
    output logic [1:0]             rx_gray,
    // Interrupt.
    output logic                   irq
);
    import pse_pkg::*;
    localparam int PAW = $clog2(PAT_D);

    function automatic logic [CNT_W-1:0] sat(
        input logic [CNT_W-1:0] c, input logic [1:0] inc);
        logic [CNT_W:0] s;
        s = {1'b0, c} + {{(CNT_W-1){1'b0}}, inc};
        return s[CNT_W] ? {CNT_W{1'b1}} : s[CNT_W-1:0];
    endfunction

    function automatic logic [1:0] lut(input pse_samp_t s);
        case (s)
            3'b000:  lut = 2'h0;
            3'b001:  lut = 2'h1;
            3'b011:  lut = 2'h2;
            3'b111:  lut = 2'h3;
            default: lut = 2'(s.upp + s.mid + s.low);
        endcase
    endfunction

    function automatic logic [1:0] gray(input logic [1:0] l);
        return {l[1], l[1] ^ l[0]};
    endfunction

    function automatic logic [30:0] prbs2(input logic [30:0] s);
        logic [30:0] t;
        t = s;
        for (int i = 0; i < 2; i++) begin
            t = {t[29:0], t[PRBS_TA] ^ t[PRBS_TB]};
        end
        return t;
    endfunction

    //--------------------------------------------------------------
    // Bus slave
    //--------------------------------------------------------------
    pse_bus_t            bs_reg;
    logic [ADDR_W-1:0]   adr_reg;
    logic                wr_reg;
    logic                map_reg;
    logic                accept;
    logic                wr_stb;
    logic [31:0]         rdata;

    assign accept = hsel && htrans[1] && hready;
    assign wr_stb = (bs_reg == BS_WAIT) && wr_reg && map_reg;

    // One wait state lets a read see a write made just before it.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bs_reg    <= BS_IDLE;
            adr_reg   <= '0;
            wr_reg    <= 1'b0;
            map_reg   <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= '0;
        end else begin
            case (bs_reg)
                BS_WAIT: begin
                    bs_reg    <= BS_DONE;
                    hreadyout <= 1'b1;
                    hrdata    <= wr_reg ? 32'h0 : rdata;
                end
                BS_IDLE, BS_DONE: begin
                    if (accept) begin
                        bs_reg    <= BS_WAIT;
                        hreadyout <= 1'b0;
                        adr_reg   <= haddr[ADDR_W-1:0];
                        wr_reg    <= hwrite;
                        map_reg   <= haddr[31:ADDR_W] == '0;
                    end else begin
                        bs_reg <= BS_IDLE;
                    end
                end
                default: begin
                    bs_reg    <= BS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    //--------------------------------------------------------------
    // Control registers
    //--------------------------------------------------------------
    logic [CTL_W-1:0]    ctl_reg;
    logic [IRQ_W-1:0]    msk_reg;
    logic [30:0]         seed_reg;
    logic [PAW-1:0]      plen_reg;
    logic [PAW-1:0]      padr_reg;
    logic                start;
    logic                slc_on;
    pse_pat_t            pat_mem [PAT_D];

    assign start = wr_stb && adr_reg == OFS_CTRL && hwdata[CTL_START];
    assign slc_on = ctl_reg[CTL_SLC] && ctl_reg[CTL_MEM] // R13
        && slc_aligned; // R12

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_reg  <= '0;
            msk_reg  <= '0;
            seed_reg <= SEED_RST;
            plen_reg <= '1;
            thr_upp  <= THR_W'(THR_U_RST);
            thr_mid  <= THR_W'(THR_M_RST);
            thr_low  <= THR_W'(THR_L_RST);
        end else if (wr_stb) begin
            case (adr_reg)
                OFS_CTRL:  ctl_reg  <= hwdata[CTL_W-1:0]; // R16
                OFS_MASK:  msk_reg  <= hwdata[IRQ_W-1:0];
                OFS_SEED:  seed_reg <= hwdata[30:0];
                OFS_PLEN:  plen_reg <= hwdata[PAW-1:0];
                OFS_THR_U: thr_upp  <= hwdata[THR_W-1:0]; // R14
                OFS_THR_M: thr_mid  <= hwdata[THR_W-1:0]; // R14
                OFS_THR_L: thr_low  <= hwdata[THR_W-1:0]; // R14
                default: ;
            endcase
        end
    end

    // Pattern and mask codes are loaded by software with auto-increment.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            padr_reg <= '0;
        end else if (wr_stb && adr_reg == OFS_PADR) begin
            padr_reg <= hwdata[PAW-1:0];
        end else if (wr_stb && adr_reg == OFS_PDAT) begin
            padr_reg <= padr_reg + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (wr_stb && adr_reg == OFS_PDAT) begin
            pat_mem[padr_reg] <= pse_pat_t'(hwdata[4:0]); // R9
        end
    end

    //--------------------------------------------------------------
    // Sampling and expected symbol
    //--------------------------------------------------------------
    pse_samp_t           samp_reg;
    logic                svld_reg;
    logic [30:0]         prbs_reg;
    logic [PAW-1:0]      ptr_reg;
    pse_pat_t            pat;
    logic [1:0]          exp_lvl;
    logic [1:0]          exp_gry;
    logic [1:0]          got_lvl;
    logic [1:0]          bit_dif;
    logic [2:0]          exp_thm;
    logic [2:0]          rel;
    logic [2:0]          slc_err;
    logic                sym_bad;
    logic                wrap;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            samp_reg <= '0;
            svld_reg <= 1'b0;
        end else begin
            samp_reg <= sym_valid ? {cmp_upp, cmp_mid, cmp_low} // R1
                                  : samp_reg;
            svld_reg <= sym_valid && ctl_reg[CTL_EN] && !start;
        end
    end

    assign pat     = pat_mem[ptr_reg];
    assign exp_gry = ctl_reg[CTL_MEM] ? gray(pat.lvl)
                                      : prbs_reg[PRBS_TA -: 2]; // R8
    assign exp_lvl = {exp_gry[1], exp_gry[1] ^ exp_gry[0]};
    assign got_lvl = lut(samp_reg); // R2
    assign bit_dif = gray(got_lvl) ^ exp_gry; // R17
    assign exp_thm = {exp_lvl == 2'h3, exp_lvl[1], exp_lvl != 2'h0};
    assign wrap    = ctl_reg[CTL_MEM] && ptr_reg == plen_reg;

    always_comb begin
        case (exp_lvl)
            2'h0:    rel = REL_L0; // R11
            2'h1:    rel = REL_L1;
            2'h2:    rel = REL_L2;
            default: rel = REL_L3;
        endcase
    end

    // Memory mask and fixed relevance both gate, so a bad mask code
    // can never bring back double counting.
    assign slc_err = (samp_reg ^ exp_thm) & pat.mask & rel; // R10
    assign sym_bad = slc_on ? |slc_err : got_lvl != exp_lvl; // R4 R7

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prbs_reg <= SEED_RST;
            ptr_reg  <= '0;
        end else if (start) begin
            prbs_reg <= seed_reg;
            ptr_reg  <= '0;
        end else if (svld_reg) begin
            prbs_reg <= prbs2(prbs_reg); // R8
            ptr_reg  <= wrap ? '0 : ptr_reg + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_level <= 2'h0;
            rx_gray  <= 2'h0;
        end else if (svld_reg) begin
            rx_level <= got_lvl; // R2
            rx_gray  <= gray(got_lvl); // R3
        end
    end

    //--------------------------------------------------------------
    // Counters
    //--------------------------------------------------------------
    logic [CNT_W-1:0]    syms_reg;
    logic [CNT_W-1:0]    syme_reg;
    logic [CNT_W-1:0]    bits_reg;
    logic [CNT_W-1:0]    bite_reg;
    logic [CNT_W-1:0]    bems_reg;
    logic [CNT_W-1:0]    bels_reg;
    logic [CNT_W-1:0]    scmp_reg [4];
    logic [CNT_W-1:0]    serr_reg [4];

    // No capture memory: counters update on the edge after the symbol is sampled.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            syms_reg <= '0;
            syme_reg <= '0;
            bits_reg <= '0;
            bite_reg <= '0;
            bems_reg <= '0;
            bels_reg <= '0;
        end else if (start) begin
            syms_reg <= '0; // R18
            syme_reg <= '0;
            bits_reg <= '0;
            bite_reg <= '0;
            bems_reg <= '0;
            bels_reg <= '0;
        end else if (svld_reg) begin
            syms_reg <= sat(syms_reg, 2'h1); // R6
            syme_reg <= sat(syme_reg, {1'b0, sym_bad}); // R4 R7
            bits_reg <= sat(bits_reg, 2'h2); // R17
            bite_reg <= sat(bite_reg,
                2'(bit_dif[1] + bit_dif[0])); // R15
            bems_reg <= sat(bems_reg, {1'b0, bit_dif[1]});
            bels_reg <= sat(bels_reg, {1'b0, bit_dif[0]});
        end
    end

    for (genvar g = 0; g < 4; g++) begin : g_sym
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                scmp_reg[g] <= '0;
                serr_reg[g] <= '0;
            end else if (start) begin
                scmp_reg[g] <= '0;
                serr_reg[g] <= '0;
            end else if (svld_reg && exp_lvl == 2'(g)) begin
                scmp_reg[g] <= sat(scmp_reg[g], 2'h1); // R5
                serr_reg[g] <= sat(serr_reg[g], {1'b0, sym_bad});
            end
        end
    end

    //--------------------------------------------------------------
    // Interrupts
    //--------------------------------------------------------------
    logic [IRQ_W-1:0]    stat_reg;
    logic [IRQ_W-1:0]    ev;
    logic [IRQ_W-1:0]    clr;

    assign ev[IRQ_SERR] = svld_reg && sym_bad;
    assign ev[IRQ_SAT]  = svld_reg && syms_reg == '1;
    assign ev[IRQ_WRAP] = svld_reg && wrap;
    assign clr = (wr_stb && adr_reg == OFS_STAT) ? hwdata[IRQ_W-1:0]
                                                 : '0;

    // A new event beats a clear in the same cycle.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stat_reg <= '0;
            irq      <= 1'b0;
        end else begin
            stat_reg <= (stat_reg & ~clr) | ev;
            irq      <= |(((stat_reg & ~clr) | ev) & msk_reg);
        end
    end

    //--------------------------------------------------------------
    // Read multiplexer
    //--------------------------------------------------------------
    always_comb begin
        rdata = 32'h0;
        if (map_reg) begin
            case (adr_reg)
                OFS_CTRL:  rdata = 32'(ctl_reg);
                OFS_STAT:  rdata = 32'(stat_reg);
                OFS_MASK:  rdata = 32'(msk_reg);
                OFS_THR_U: rdata = 32'(thr_upp);
                OFS_THR_M: rdata = 32'(thr_mid);
                OFS_THR_L: rdata = 32'(thr_low);
                OFS_SEED:  rdata = 32'(seed_reg);
                OFS_PLEN:  rdata = 32'(plen_reg);
                OFS_PADR:  rdata = 32'(padr_reg);
                OFS_PDAT:  rdata = 32'(pat_mem[padr_reg]);
                OFS_SYMS:  rdata = 32'(syms_reg);
                OFS_SYME:  rdata = 32'(syme_reg);
                OFS_BITS:  rdata = 32'(bits_reg);
                OFS_BITE:  rdata = 32'(bite_reg);
                OFS_BEMS:  rdata = 32'(bems_reg);
                OFS_BELS:  rdata = 32'(bels_reg);
                OFS_RXST:  rdata = 32'({slc_on, rx_gray, rx_level});
                default: begin
                    if (adr_reg[7:4] == PAGE_SCMP) begin
                        rdata = 32'(scmp_reg[adr_reg[3:2]]);
                    end else if (adr_reg[7:4] == PAGE_SERR) begin
                        rdata = 32'(serr_reg[adr_reg[3:2]]);
                    end
                end
            endcase
        end
    end

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_capture;
        sym_valid |=> samp_reg ==
            {$past(cmp_upp), $past(cmp_mid), $past(cmp_low)};
    endproperty
    a_capture: assert property (p_capture) // R1
        else $error("comparator bits not captured together");

    property p_lut;
        svld_reg && samp_reg == 3'b011 |=> rx_level == 2'h2;
    endproperty
    a_lut: assert property (p_lut) // R2
        else $error("code 011 did not decode to level 2");

    property p_gray;
        svld_reg |=> rx_gray == {rx_level[1], rx_level[1] ^ rx_level[0]};
    endproperty
    a_gray: assert property (p_gray) // R3
        else $error("gray code does not match level");

    property p_once;
        svld_reg && !start && !slc_on && got_lvl != exp_lvl
            && syme_reg < 32'd100 |=> syme_reg == $past(syme_reg) + 1;
    endproperty
    a_once: assert property (p_once) // R7
        else $error("symbol error not counted exactly once");

    property p_bits;
        svld_reg && !start && bits_reg < 32'd100
            |=> bits_reg == $past(bits_reg) + 2;
    endproperty
    a_bits: assert property (p_bits) // R17
        else $error("compared bits did not grow by two");

    property p_lowonly;
        svld_reg && !start && slc_on && exp_lvl == 2'h0 && !samp_reg.low
            |=> $stable(syme_reg);
    endproperty
    a_lowonly: assert property (p_lowonly) // R11
        else $error("upper slicers counted for expected zero");

    property p_memonly;
        slc_on |-> ctl_reg[CTL_MEM] && slc_aligned;
    endproperty
    a_memonly: assert property (p_memonly) // R13
        else $error("three-slicer mode active without memory");

    property p_clear;
        start |=> syms_reg == '0 && bite_reg == '0 && scmp_reg[0] == '0;
    endproperty
    a_clear: assert property (p_clear) // R18
        else $error("start did not clear counters");

    property p_irq;
        (|(stat_reg & msk_reg)) && clr == '0 |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt missing for unmasked status");
endmodule
`default_nettype wire

// ### tb/pse_tx_model.sv
/*
 Behavioural serial transmitter that feeds the checker's comparators.
 Assumes send is called just after a rising edge of clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pse_tx_model (
    // Clock.
    input  wire logic clk,
    // Comparator lines and symbol strobe.
    output var  logic cmp_upp,
    output var  logic cmp_mid,
    output var  logic cmp_low,
    output var  logic sym_valid
);
    initial begin
        {cmp_upp, cmp_mid, cmp_low} = 3'h0;
        sym_valid = 1'h0;
    end

    // Between symbols the lines show the inverse, so a late sample is wrong.
    task automatic send(input logic [1:0] lvl, input logic hold);
        logic [2:0] t;
        t = (lvl == 2'h0) ? 3'h0 : (lvl == 2'h1) ? 3'h1 :
            (lvl == 2'h2) ? 3'h3 : 3'h7;
        {cmp_upp, cmp_mid, cmp_low} <= t;
        sym_valid <= 1'h1;
        @(posedge clk);
        if (!hold) begin
            {cmp_upp, cmp_mid, cmp_low} <= ~t;
            sym_valid <= 1'h0;
        end
    endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
/*
 Self-checking bench for the four-level symbol error checker.
 Assumes pse_pkg, pse_checker and pse_tx_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pse_pkg::*;
    logic        clk;
    logic        rst_b;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        cmp_upp, cmp_mid, cmp_low, sym_valid;
    logic        slc_aligned;
    logic [7:0]  thr_upp, thr_mid, thr_low;
    logic [1:0]  rx_level, rx_gray;
    logic        irq;
    logic [31:0] rd;
    int          n_fail;
    int          checks_done;

    initial clk = 1'h0;
    always #12.5 clk = ~clk;

    pse_checker dut_u (.clk(clk), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .cmp_upp(cmp_upp),
        .cmp_mid(cmp_mid), .cmp_low(cmp_low), .sym_valid(sym_valid),
        .slc_aligned(slc_aligned), .thr_upp(thr_upp), .thr_mid(thr_mid),
        .thr_low(thr_low), .rx_level(rx_level), .rx_gray(rx_gray),
        .irq(irq));

    pse_tx_model tx_u (.clk(clk), .cmp_upp(cmp_upp), .cmp_mid(cmp_mid),
        .cmp_low(cmp_low), .sym_valid(sym_valid));

    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        if (n_fail == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'h1) begin
            n++;
            if (n > 50) begin
                n_fail++;
                close_out();
            end
            @(posedge clk);
        end
    endtask

    task automatic ahb(input logic [31:0] a, input logic w,
                       input logic [31:0] wd);
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb({24'h0, a}, 1'h1, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        ahb({24'h0, a}, 1'h0, 32'h0);
        chk(rd, exp);
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic s_regs();
        rdc(OFS_THR_U, 32'hC0);
        rdc(OFS_THR_L, 32'h40);
        wr(OFS_THR_M, 32'h5A);
        rdc(OFS_THR_M, 32'h5A);
        chk(32'(thr_mid), 32'h5A);
        chk(32'(thr_upp), 32'hC0);
        chk(32'(thr_low), 32'h40);
        ahb(32'h100, 1'h1, 32'hFF);
        ahb(32'h100, 1'h0, 32'h0);
        chk(rd, 32'h0);
        chk(32'(hresp), 32'h0);
    endtask

    // Pattern 0,1,2,3 with every slicer let through by the mask code.
    task automatic s_decode();
        wr(OFS_PLEN, 32'h3);
        wr(OFS_PADR, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_PDAT, {27'h0, 3'h7, i[1:0]});
        end
        wr(OFS_CTRL, 32'hB);
        for (int i = 0; i < 4; i++) begin
            tx_u.send(i[1:0], 1'h0);
            @(posedge clk);
            #1;
            chk(32'(rx_level), i);
            chk(32'(rx_gray), 32'(i[1:0] ^ {1'h0, i[1]}));
        end
        rdc(OFS_SYMS, 32'h4);
        rdc(OFS_SYME, 32'h0);
        rdc(OFS_BITS, 32'h8);
        for (int i = 0; i < 4; i++) begin
            rdc(8'h40 + 8'(4 * i), 32'h1);
        end
    endtask

    // Level 3 (Gray 10) against 0,1,2,3: Gray differences 1,2,1,0 bits.
    task automatic s_errors();
        for (int i = 0; i < 4; i++) begin
            tx_u.send(2'h3, i < 3);
        end
        settle();
        rdc(OFS_SYMS, 32'h8);
        rdc(OFS_SYME, 32'h3);
        rdc(OFS_BITS, 32'h10);
        rdc(OFS_BITE, 32'h4);
        rdc(OFS_BEMS, 32'h2);
        rdc(OFS_BELS, 32'h2);
        for (int i = 0; i < 4; i++) begin
            rdc(8'h50 + 8'(4 * i), 32'(i != 3));
        end
    endtask

    task automatic s_irq();
        wr(OFS_MASK, 32'h0);
        settle();
        chk(32'(irq), 32'h0);
        ahb({24'h0, OFS_STAT}, 1'h0, 32'h0);
        chk(32'(rd[IRQ_SERR]), 32'h1);
        wr(OFS_MASK, 32'h1);
        settle();
        chk(32'(irq), 32'h1);
        wr(OFS_STAT, 32'h1);
        settle();
        chk(32'(irq), 32'h0);
    endtask

    task automatic s_start();
        wr(OFS_CTRL, 32'hB);
        rdc(OFS_SYMS, 32'h0);
        rdc(OFS_SYME, 32'h0);
        rdc(OFS_BITE, 32'h0);
        rdc(8'h50, 32'h0);
    endtask

    // Expected 0, received 3: only the lower slicer may count.
    task automatic s_slicer();
        slc_aligned <= 1'h1;
        wr(OFS_CTRL, 32'hF);
        ahb({24'h0, OFS_RXST}, 1'h0, 32'h0);
        chk(32'(rd[4]), 32'h1);
        tx_u.send(2'h3, 1'h0);
        settle();
        rdc(OFS_SYME, 32'h1);
        wr(OFS_CTRL, 32'hF);
        tx_u.send(2'h0, 1'h0);
        settle();
        rdc(OFS_SYME, 32'h0);
        slc_aligned <= 1'h0;
        settle();
        ahb({24'h0, OFS_RXST}, 1'h0, 32'h0);
        chk(32'(rd[4]), 32'h0);
        slc_aligned <= 1'h1;
        wr(OFS_CTRL, 32'hD);
        ahb({24'h0, OFS_RXST}, 1'h0, 32'h0);
        chk(32'(rd[4]), 32'h0);
    endtask

    task automatic s_prbs();
        wr(OFS_CTRL, 32'h9);
        for (int i = 0; i < 10; i++) begin
            tx_u.send(2'(i), i < 9);
        end
        settle();
        rdc(OFS_SYMS, 32'hA);
        rdc(OFS_BITS, 32'h14);
    endtask

    initial begin
        n_fail = 0;
        checks_done = 0;
        rst_b = 1'h0;
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        slc_aligned = 1'h0;
        repeat (8) @(posedge clk);
        rst_b <= 1'h1;
        @(posedge clk);
        chk(32'(hreadyout), 32'h1);
        s_regs();
        s_decode();
        s_errors();
        s_irq();
        s_start();
        s_slicer();
        s_prbs();
        close_out();
    end
endmodule
`default_nettype wire
